// *** core/mcsc_pkg.sv ***
// constants shared by the sample clock and multichip sync control block
// assumes a single 125 MHz clock and a plain one-cycle register port
package mcsc_pkg;

  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned DATA_W    = 16;

  // register indexes; the byte address is four times the index
  localparam logic [5:0] CFG_IDX    = 6'h00;
  localparam logic [5:0] SYNC_IDX   = 6'h0E;
  localparam logic [5:0] STAT_IDX   = 6'h0F;
  localparam logic [7:0] CFG_ADDR   = {CFG_IDX, 2'b00};
  localparam logic [7:0] SYNC_ADDR  = {SYNC_IDX, 2'b00};
  localparam logic [7:0] STAT_ADDR  = {STAT_IDX, 2'b00};

  // field positions
  localparam int unsigned QSEL_BIT  = 6;
  localparam int unsigned SEC_BIT   = 0;
  localparam int unsigned REFO_BIT  = 1;
  localparam int unsigned ASEN_BIT  = 2;
  localparam int unsigned RDLY_LSB  = 7;
  localparam int unsigned RDLY_W    = 9;

  // values after reset
  localparam logic [15:0] CFG_RST   = 16'h0000;
  localparam logic [15:0] SYNC_RST  = 16'h0000;

  // divider: output data clock and reference clock taps
  localparam int unsigned DIV_W     = 4;
  localparam int unsigned DCLK_BIT  = 1;
  localparam int unsigned RC_BIT_SDR = 2;
  localparam int unsigned RC_BIT_DES = 3;
  localparam logic [3:0]  DIV_RST   = 4'h0;

  typedef enum logic [1:0] {
    SYNC_OFF  = 2'b00,
    SYNC_WAIT = 2'b01,
    SYNC_LOCK = 2'b10
  } mcsc_sync_e;

endpackage : mcsc_pkg

// *** core/mcsc_ref_delay.sv ***
// programmable delay line for the incoming reference clock edge
// assumes i_edge is a one-cycle pulse already in the i_mclk domain
`timescale 1ns/1ps
module mcsc_ref_delay #(
  parameter int unsigned SEL_W = 9
) (
  input  wire logic             i_mclk,
  input  wire logic             i_rst,
  input  wire logic             i_edge,
  input  wire logic [SEL_W-1:0] i_delay,
  output logic                  o_edge
);
  localparam int unsigned DEPTH = 1 << SEL_W;

  logic [DEPTH-1:0] line_r;
  logic [DEPTH-1:0] line_nxt;
  logic             edge_r;
  logic             edge_nxt;

  always_comb
  begin
    line_nxt = {line_r[DEPTH-2:0], i_edge};
    // zero delay taps the input itself; every tap adds the same output stage
    edge_nxt = (i_delay == '0) ? i_edge : line_r[i_delay - 1'b1];
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      line_r <= '0;
      edge_r <= 1'b0;
    end
    else
    begin
      line_r <= line_nxt;
      edge_r <= edge_nxt;
    end
  end

  assign o_edge = edge_r;

endmodule : mcsc_ref_delay

// *** core/mcsc_clock_sync.sv ***
// sample clock edge selection, output clock reset and multichip alignment
// assumes all pins are asynchronous to i_mclk; registers sit on a plain port
// Function
// - non-dual-edge: sample inputs on rising edges only
// - dual-edge: sample selected input on both edges
// - reset pulse resets both output data clocks
// - I and Q data clocks stay in phase
// - secondary with sync active aligns divider to reference
// - extended control delays reference by delay field
// - reference outputs driven only when enable set
// - reference rate depends only on mode
// - grounded common-mode pin selects AC coupling
// - high bandgap pin selects higher LVDS level
// - dual-edge input is I unless select bit
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
module mcsc_clock_sync (
  input  wire logic                        i_mclk,
  input  wire logic                        i_rst,
  input  wire logic [mcsc_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [mcsc_pkg::DATA_W-1:0] i_wdata,
  input  wire logic                        i_we,
  input  wire logic                        i_re,
  output logic      [mcsc_pkg::DATA_W-1:0] o_rdata,
  input  wire logic                        i_dual_edge_mode,
  input  wire logic                        i_extended_control_mode,
  input  wire logic                        i_power_down_i,
  input  wire logic                        i_power_down_q,
  input  wire logic                        i_output_clock_reset_in,
  input  wire logic                        i_sync_reference_clock_in,
  input  wire logic                        i_common_mode_pin,
  input  wire logic                        i_bandgap_level_select_pin,
  output logic                             o_sample_i_rise,
  output logic                             o_sample_q_rise,
  output logic                             o_sample_fall,
  output logic                             o_sample_q_sel,
  output logic                             o_i_channel_output_clock,
  output logic                             o_q_channel_output_clock,
  output logic                             o_sync_reference_clock_out_a,
  output logic                             o_sync_reference_clock_out_b,
  output logic                             o_ac_coupled,
  output logic                             o_common_mode_drive,
  output logic                             o_common_mode_oe_n,
  output logic                             o_lvds_cm_high
);

  // pin synchronisers; stage one is read only by stage two
  logic [7:0] meta_r;
  logic [7:0] sync_r;
  logic       des_s;
  logic       xctl_s;
  logic       pdi_s;
  logic       pdq_s;
  logic       ocr_s;
  logic       ref_s;
  logic       cm_s;
  logic       bg_s;

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      meta_r <= 8'h00;
      sync_r <= 8'h00;
    end
    else
    begin
      meta_r <= {i_bandgap_level_select_pin, i_common_mode_pin,
                 i_sync_reference_clock_in, i_output_clock_reset_in,
                 i_power_down_q, i_power_down_i,
                 i_extended_control_mode, i_dual_edge_mode};
      sync_r <= meta_r;
    end
  end

  assign des_s = sync_r[0];
  assign xctl_s = sync_r[1];
  assign pdi_s = sync_r[2];
  assign pdq_s = sync_r[3];
  assign ocr_s = sync_r[4];
  assign ref_s = sync_r[5];
  assign cm_s  = sync_r[6];
  assign bg_s  = sync_r[7];

  // registers
  logic [15:0]                 cfg_r;
  logic [15:0]                 cfg_nxt;
  logic [15:0]                 ctl_r;
  logic [15:0]                 ctl_nxt;
  logic [mcsc_pkg::DATA_W-1:0] rdata_r;
  logic [mcsc_pkg::DATA_W-1:0] rdata_nxt;
  mcsc_pkg::mcsc_sync_e        st_r;
  mcsc_pkg::mcsc_sync_e        st_nxt;

  // effective controls: outside extended control the pin defaults apply
  logic                        qsel_eff;
  logic                        refo_eff;
  logic                        sec_eff;
  logic [mcsc_pkg::RDLY_W-1:0] dly_eff;

  always_comb
  begin
    qsel_eff = xctl_s & cfg_r[mcsc_pkg::QSEL_BIT];
    refo_eff = xctl_s & ctl_r[mcsc_pkg::REFO_BIT];
    sec_eff  = xctl_s & ctl_r[mcsc_pkg::SEC_BIT] & ctl_r[mcsc_pkg::ASEN_BIT];
    dly_eff  = xctl_s ? ctl_r[mcsc_pkg::RDLY_LSB +: mcsc_pkg::RDLY_W]
                      : '0;
  end

  // reference edge and output clock reset edge detection on synced levels
  logic ref_d_r;
  logic ocr_d_r;
  logic ref_edge;
  logic ocr_edge;
  logic ref_dly_edge;

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      ref_d_r <= 1'b0;
      ocr_d_r <= 1'b0;
    end
    else
    begin
      ref_d_r <= ref_s;
      ocr_d_r <= ocr_s;
    end
  end

  assign ref_edge = ref_s & ~ref_d_r;
  // the pulse passes the same two-stage synchroniser as every other pin
  assign ocr_edge = ocr_s & ~ocr_d_r;

  mcsc_ref_delay #(
    .SEL_W (mcsc_pkg::RDLY_W)
  ) u_delay (
    .i_mclk  (i_mclk),
    .i_rst   (i_rst),
    .i_edge  (ref_edge),
    .i_delay (dly_eff),
    .o_edge  (ref_dly_edge)
  );

  // divider shared by both data clocks and the reference outputs
  logic [mcsc_pkg::DIV_W-1:0] div_r;
  logic [mcsc_pkg::DIV_W-1:0] div_nxt;
  logic                       align;

  always_comb
  begin
    align   = sec_eff & ref_dly_edge;
    div_nxt = div_r + 1'b1;
    if (ocr_edge)
      div_nxt = mcsc_pkg::DIV_RST;
    else if (align)
      div_nxt = mcsc_pkg::DIV_RST;
  end

  // alignment state, visible in the status register
  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      mcsc_pkg::SYNC_OFF:
        if (sec_eff)
          st_nxt = mcsc_pkg::SYNC_WAIT;
      mcsc_pkg::SYNC_WAIT:
        if (!sec_eff)
          st_nxt = mcsc_pkg::SYNC_OFF;
        else if (align)
          st_nxt = mcsc_pkg::SYNC_LOCK;
      mcsc_pkg::SYNC_LOCK:
        if (!sec_eff)
          st_nxt = mcsc_pkg::SYNC_OFF;
      default:
        st_nxt = mcsc_pkg::SYNC_OFF;
    endcase
  end

  // register port; reads answer one cycle later, unmapped reads give zero
  always_comb
  begin
    cfg_nxt   = cfg_r;
    ctl_nxt   = ctl_r;
    rdata_nxt = '0;
    if (i_we)
    begin
      case (i_addr)
        mcsc_pkg::CFG_ADDR:  cfg_nxt = i_wdata;
        mcsc_pkg::SYNC_ADDR: ctl_nxt = i_wdata;
        default:             ;
      endcase
    end
    if (i_re)
    begin
      case (i_addr)
        mcsc_pkg::CFG_ADDR:  rdata_nxt = cfg_r;
        mcsc_pkg::SYNC_ADDR: rdata_nxt = ctl_r;
        mcsc_pkg::STAT_ADDR: rdata_nxt = {8'h00, st_r, xctl_s, des_s,
                                          pdq_s, pdi_s, cm_s, bg_s};
        default:             rdata_nxt = '0;
      endcase
    end
  end

  // sampling strobes and output clocks
  logic out_sir_nxt;
  logic out_sqr_nxt;
  logic out_sf_nxt;
  logic out_qs_nxt;
  logic out_ci_nxt;
  logic out_cq_nxt;
  logic out_ra_nxt;
  logic out_rb_nxt;
  logic rc_tap;

  always_comb
  begin
    // one rising strobe per channel, or one input on both edges
    out_sir_nxt = des_s ? ~qsel_eff : ~pdi_s;
    out_sqr_nxt = des_s ? qsel_eff : ~pdq_s;
    out_sf_nxt  = des_s;
    out_qs_nxt  = des_s & qsel_eff;
    // both data clocks come from one counter bit, so they cannot drift
    out_ci_nxt  = div_nxt[mcsc_pkg::DCLK_BIT] & ~pdi_s;
    out_cq_nxt  = div_nxt[mcsc_pkg::DCLK_BIT] & ~pdq_s;
    // tap depends on mode only, never on primary or secondary role
    rc_tap      = des_s ? div_nxt[mcsc_pkg::RC_BIT_DES]
                        : div_nxt[mcsc_pkg::RC_BIT_SDR];
    out_ra_nxt  = refo_eff & rc_tap;
    out_rb_nxt  = refo_eff & rc_tap;
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      cfg_r                        <= mcsc_pkg::CFG_RST;
      ctl_r                        <= mcsc_pkg::SYNC_RST;
      rdata_r                      <= '0;
      st_r                         <= mcsc_pkg::SYNC_OFF;
      div_r                        <= mcsc_pkg::DIV_RST;
      o_sample_i_rise              <= 1'b0;
      o_sample_q_rise              <= 1'b0;
      o_sample_fall                <= 1'b0;
      o_sample_q_sel               <= 1'b0;
      o_i_channel_output_clock     <= 1'b0;
      o_q_channel_output_clock     <= 1'b0;
      o_sync_reference_clock_out_a <= 1'b0;
      o_sync_reference_clock_out_b <= 1'b0;
      o_ac_coupled                 <= 1'b1;
      o_common_mode_drive          <= 1'b0;
      o_common_mode_oe_n           <= 1'b1;
      o_lvds_cm_high               <= 1'b0;
    end
    else
    begin
      cfg_r                        <= cfg_nxt;
      ctl_r                        <= ctl_nxt;
      rdata_r                      <= rdata_nxt;
      st_r                         <= st_nxt;
      div_r                        <= div_nxt;
      o_sample_i_rise              <= out_sir_nxt;
      o_sample_q_rise              <= out_sqr_nxt;
      o_sample_fall                <= out_sf_nxt;
      o_sample_q_sel               <= out_qs_nxt;
      o_i_channel_output_clock     <= out_ci_nxt;
      o_q_channel_output_clock     <= out_cq_nxt;
      o_sync_reference_clock_out_a <= out_ra_nxt;
      o_sync_reference_clock_out_b <= out_rb_nxt;
      // grounded pin means AC coupling; else drive the common-mode level
      o_ac_coupled                 <= ~cm_s;
      o_common_mode_drive          <= cm_s;
      o_common_mode_oe_n           <= ~cm_s;
      o_lvds_cm_high               <= bg_s;
    end
  end

  assign o_rdata = rdata_r;

  // checks
  property p_rise_only;
    @(posedge i_mclk) disable iff (i_rst)
      !des_s |=> !o_sample_fall && !o_sample_q_sel;
  endproperty
  a_rise_only: assert property (p_rise_only) else $error("fall strobe outside dual-edge");

  property p_des_both;
    @(posedge i_mclk) disable iff (i_rst)
      des_s |=> o_sample_fall && (o_sample_i_rise != o_sample_q_rise);
  endproperty
  a_des_both: assert property (p_des_both) else $error("dual-edge strobes wrong");

  property p_ocr_reset;
    @(posedge i_mclk) disable iff (i_rst)
      ocr_edge |=> div_r == mcsc_pkg::DIV_RST && !o_i_channel_output_clock;
  endproperty
  a_ocr_reset: assert property (p_ocr_reset) else $error("data clock not reset");

  property p_iq_phase;
    @(posedge i_mclk) disable iff (i_rst)
      !pdi_s && !pdq_s |=> o_i_channel_output_clock == o_q_channel_output_clock;
  endproperty
  a_iq_phase: assert property (p_iq_phase) else $error("I and Q data clocks apart");

  property p_align;
    @(posedge i_mclk) disable iff (i_rst)
      sec_eff && ref_dly_edge && !ocr_edge |=> div_r == mcsc_pkg::DIV_RST ##1 div_r == 4'h1;
  endproperty
  a_align: assert property (p_align) else $error("divider not aligned");

  property p_delay;
    @(posedge i_mclk) disable iff (i_rst)
      xctl_s && ref_edge && dly_eff == '0 |=> ref_dly_edge;
  endproperty
  a_delay: assert property (p_delay) else $error("delay not taken from field");

  property p_ref_off;
    @(posedge i_mclk) disable iff (i_rst)
      !refo_eff |=> !o_sync_reference_clock_out_a && !o_sync_reference_clock_out_b;
  endproperty
  a_ref_off: assert property (p_ref_off) else $error("reference out while disabled");

  property p_ref_rate;
    @(posedge i_mclk) disable iff (i_rst)
      refo_eff && des_s && !ocr_edge && !align |=>
        o_sync_reference_clock_out_a == div_r[mcsc_pkg::RC_BIT_DES];
  endproperty
  a_ref_rate: assert property (p_ref_rate) else $error("reference rate wrong");

  property p_coupling;
    @(posedge i_mclk) disable iff (i_rst)
      !cm_s ##1 !cm_s |-> o_ac_coupled && o_common_mode_oe_n;
  endproperty
  a_coupling: assert property (p_coupling) else $error("coupling mode wrong");

  property p_lvds;
    @(posedge i_mclk) disable iff (i_rst)
      bg_s |=> o_lvds_cm_high;
  endproperty
  a_lvds: assert property (p_lvds) else $error("LVDS level not raised");

  property p_dual_i;
    @(posedge i_mclk) disable iff (i_rst)
      des_s && !xctl_s |=> o_sample_i_rise && !o_sample_q_rise;
  endproperty
  a_dual_i: assert property (p_dual_i) else $error("dual-edge input not I");

  property p_default;
    @(posedge i_mclk) disable iff (i_rst)
      !xctl_s |=> !o_sync_reference_clock_out_a && !o_sample_q_sel && st_r == mcsc_pkg::SYNC_OFF;
  endproperty
  a_default: assert property (p_default) else $error("fields act outside ext control");

endmodule : mcsc_clock_sync

// *** test/mcsc_peer_model.sv ***
// upstream peer converter: reference clock source and output clock reset pulser
// assumes it shares i_mclk with the block and is steered by the bench
`timescale 1ns/1ps
module mcsc_peer_model (
  input  wire logic i_mclk,
  input  wire logic i_rst,
  input  wire logic i_ref_run,
  input  wire logic i_pulse_req,
  output logic      o_ref_clk,
  output logic      o_clk_rst
);
  logic [3:0] ref_cnt_r;
  logic [1:0] pulse_cnt_r;

  // this peer sits at the root of a reference tree feeding the block's input
  // reference stands low between bursts, period 16 cycles while running
  always_ff @(posedge i_mclk)
  begin
    if (i_rst || !i_ref_run)
      ref_cnt_r <= 4'h0;
    else
      ref_cnt_r <= ref_cnt_r + 4'h1;
  end
  assign o_ref_clk = ref_cnt_r[3];

  // pulse launched just after a sampling clock edge and held 3 cycles
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
      pulse_cnt_r <= 2'h0;
    else if (i_pulse_req)
      pulse_cnt_r <= 2'h3;
    else if (pulse_cnt_r != 2'h0)
      pulse_cnt_r <= pulse_cnt_r - 2'h1;
  end
  assign o_clk_rst = (pulse_cnt_r != 2'h0);
endmodule : mcsc_peer_model

// *** test/mcsc_clock_sync_test.sv ***
// self-checking bench for the sample clock and multichip sync block
// assumes the peer model drives the reference and output clock reset pins
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin n_errors++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module mcsc_clock_sync_test;
  logic        i_mclk = 1'b0;
  logic        i_rst = 1'b1;
  logic [7:0]  i_addr = 8'h00;
  logic [15:0] i_wdata = 16'h0000;
  logic        i_we = 1'b0, i_re = 1'b0;
  logic        des = 1'b0, xctl = 1'b0, pdi = 1'b0, pdq = 1'b0, cm_pin = 1'b0, bg_pin = 1'b0;
  logic        ref_run = 1'b0, pulse_req = 1'b0;
  wire         ref_clk, clk_rst;
  wire  [15:0] o_rdata;
  wire         s_i, s_q, s_f, s_qs, dclk_i, dclk_q, rc_a, rc_b, ac, cm_drv, cm_oe_n, lvds_hi;
  int          n_errors = 0, checked = 0, rises, diffs;
  logic [15:0] rd_v;

  initial forever #4 i_mclk = ~i_mclk;

  mcsc_peer_model i_peer (.i_mclk(i_mclk), .i_rst(i_rst), .i_ref_run(ref_run), .i_pulse_req(pulse_req),
    .o_ref_clk(ref_clk), .o_clk_rst(clk_rst));

  mcsc_clock_sync i_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_we(i_we),
    .i_re(i_re), .o_rdata(o_rdata), .i_dual_edge_mode(des), .i_extended_control_mode(xctl),
    .i_power_down_i(pdi), .i_power_down_q(pdq), .i_output_clock_reset_in(clk_rst),
    .i_sync_reference_clock_in(ref_clk), .i_common_mode_pin(cm_pin), .i_bandgap_level_select_pin(bg_pin),
    .o_sample_i_rise(s_i), .o_sample_q_rise(s_q), .o_sample_fall(s_f), .o_sample_q_sel(s_qs),
    .o_i_channel_output_clock(dclk_i), .o_q_channel_output_clock(dclk_q),
    .o_sync_reference_clock_out_a(rc_a), .o_sync_reference_clock_out_b(rc_b), .o_ac_coupled(ac),
    .o_common_mode_drive(cm_drv), .o_common_mode_oe_n(cm_oe_n), .o_lvds_cm_high(lvds_hi));

  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    i_addr <= a; i_wdata <= d; i_we <= 1'b1;
    @(posedge i_mclk);
    i_we <= 1'b0;
  endtask : wr

  task chk_rd(input string nm, input logic [7:0] a, input logic [15:0] ex);
    @(posedge i_mclk);
    i_addr <= a; i_re <= 1'b1;
    @(posedge i_mclk);
    i_re <= 1'b0;
    #1;
    `CHK(nm, ex, o_rdata)
  endtask : chk_rd

  task pins(input logic d, input logic e, input logic q, input logic c, input logic b, input logic pq);
    @(posedge i_mclk);
    des <= d; xctl <= e; pdi <= q; pdq <= pq; cm_pin <= c; bg_pin <= b;
    // synchroniser plus output register
    repeat (6) @(posedge i_mclk);
    #1;
  endtask : pins

  // counts reference output rises and a/b or i/q disagreements over n cycles
  task watch(input int n);
    logic prev;
    // one settling cycle so a just-written enable is not counted as a rise
    @(posedge i_mclk);
    #1;
    prev = rc_a; rises = 0; diffs = 0;
    repeat (n)
    begin
      @(posedge i_mclk);
      #1;
      if (rc_a === 1'b1 && prev === 1'b0) rises++;
      if (rc_a !== rc_b || (!pdi && !pdq && dclk_i !== dclk_q) || (pdq && dclk_q !== 1'b0)) diffs++;
      if (pdi && dclk_i !== 1'b0) diffs++;
      prev = rc_a;
    end
  endtask : watch

  task wait_rise(input bit use_ref);
    logic prev;
    // pin is low on entry; look once after the current edge settles, so a rise launched there is seen
    prev = 1'b0;
    repeat (64)
    begin
      #1;
      if ((use_ref ? ref_clk : clk_rst) === 1'b1 && prev === 1'b0) return;
      prev = use_ref ? ref_clk : clk_rst;
      @(posedge i_mclk);
    end
    `CHK("pin rise seen", 1'b1, 1'b0)
  endtask : wait_rise

  task end_test(input string nm);
    $display("test %s done, errors so far %0d", nm, n_errors);
  endtask : end_test

  task finish_test;
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  initial
  begin
    #400000;
    n_errors++;
    finish_test();
  end

  initial
  begin
    int d;
    repeat (5) @(posedge i_mclk);
    i_rst <= 1'b0;
    chk_rd("sync reset", mcsc_pkg::SYNC_ADDR, 16'h0000);
    chk_rd("config reset", mcsc_pkg::CFG_ADDR, 16'h0000);
    `CHK("ref out after reset", 2'h0, {rc_a, rc_b})
    wr(mcsc_pkg::SYNC_ADDR, 16'hFF87);
    wr(8'h10, 16'h1234);
    chk_rd("unmapped read", 8'h10, 16'h0000);
    chk_rd("sync readback", mcsc_pkg::SYNC_ADDR, 16'hFF87);
    wr(mcsc_pkg::SYNC_ADDR, 16'h0000);
    end_test("registers");

    for (int k = 0; k < 2; k++)
    begin
      pins(1'b0, 1'b0, 1'b0, k[0], k[0], 1'b0);
      `CHK("ac coupled", ~k[0], ac)
      `CHK("cm oe_n", ~k[0], cm_oe_n)
      `CHK("cm drive", k[0], cm_drv)
      `CHK("lvds high", k[0], lvds_hi)
      chk_rd("status pins", mcsc_pkg::STAT_ADDR, {14'h0000, k[0], k[0]});
    end
    end_test("strap pins");

    wr(mcsc_pkg::CFG_ADDR, 16'h0040);
    for (int k = 0; k < 5; k++)
    begin
      logic [2:0] m;
      logic [3:0] ex;
      m = (k == 0) ? 3'b000 : (k == 1) ? 3'b100 : (k == 2) ? 3'b110 : 3'b010;
      ex = (k == 0) ? 4'hC : (k == 1) ? 4'hA : (k == 2) ? 4'h7 : 4'hC;
      if (k == 4)
      begin
        wr(mcsc_pkg::CFG_ADDR, 16'h0000);
        m = 3'b110; ex = 4'hA;
      end
      pins(m[2], m[1], 1'b0, 1'b1, 1'b0, 1'b0);
      `CHK("sample strobes", ex, {s_i, s_q, s_f, s_qs})
    end
    end_test("sampling modes");

    pins(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    watch(32);
    `CHK("i q in phase", 0, diffs)
    pins(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
    watch(32);
    `CHK("q down stays low", 0, diffs)
    pins(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
    `CHK("i down strobes", 4'h4, {s_i, s_q, s_f, s_qs})
    watch(32);
    `CHK("i down stays low", 0, diffs)
    pins(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    for (int k = 0; k < 2; k++)
    begin
      repeat (k + 1) @(posedge i_mclk);
      pulse_req <= 1'b1;
      @(posedge i_mclk);
      pulse_req <= 1'b0;
      wait_rise(1'b0);
      repeat (3) @(posedge i_mclk);
      #1;
      `CHK("dclk low after reset", 2'h0, {dclk_i, dclk_q})
      repeat (2) @(posedge i_mclk);
      #1;
      `CHK("dclk high after reset", 2'h3, {dclk_i, dclk_q})
    end
    end_test("output clock reset");

    for (int k = 0; k < 5; k++)
    begin
      int ex;
      pins(k == 3, k != 4, 1'b0, 1'b1, 1'b0, 1'b0);
      wr(mcsc_pkg::SYNC_ADDR, (k == 0) ? 16'h0000 : (k == 2) ? 16'h0003 : 16'h0002);
      ex = (k == 0 || k == 4) ? 0 : (k == 3) ? 4 : 8;
      watch(64);
      `CHK("ref out rises", ex, rises)
      `CHK("ref out a b equal", 0, diffs)
    end
    end_test("reference outputs");

    pins(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    for (int k = 0; k < 2; k++)
    begin
      d = k * 5;
      wr(mcsc_pkg::SYNC_ADDR, 16'h0007 | (16'(d) << 7));
      @(posedge i_mclk);
      ref_run <= 1'b1;
      wait_rise(1'b1);
      repeat (4 + d) @(posedge i_mclk);
      #1;
      `CHK("aligned dclk low", 1'b0, dclk_i)
      repeat (2) @(posedge i_mclk);
      #1;
      `CHK("aligned dclk high", 1'b1, dclk_i)
      @(posedge i_mclk);
      ref_run <= 1'b0;
    end
    chk_rd("sync locked", mcsc_pkg::STAT_ADDR, 16'h00A2);
    end_test("reference alignment");
    finish_test();
  end
endmodule : mcsc_clock_sync_test
